//--- hdl/twras_defs.vh
`ifndef TWRAS_DEFS_VH
`define TWRAS_DEFS_VH
`define TWRAS_DEV_ADDR     7'h21
`define TWRAS_DIR_BIT      0
`define TWRAS_ADDR_RESET   16'h0000
`define TWRAS_ADDR_TOP     16'hffff
`define TWRAS_BITS_PER_BYTE 4'h8
`endif

//--- hdl/twras_sync.v
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser with edge detection on the settled copy
module twras_sync
(
   input  wire sys_clk_i,
   input  wire rstn_i,
   input  wire async_i,
   output reg  level_o,
   output wire rise_o,
   output wire fall_o
);
   reg meta;
   reg prev;

   always @(posedge sys_clk_i)
   begin
      if (!rstn_i)
      begin
         meta    <= 1'b1;
         level_o <= 1'b1;
         prev    <= 1'b1;
      end
      else
      begin
         meta    <= async_i;
         level_o <= meta;
         prev    <= level_o;
      end
   end

   assign rise_o = level_o & ~prev;
   assign fall_o = ~level_o & prev;
endmodule // twras_sync
`default_nettype wire

//--- hdl/twras_slave.v
`timescale 1ns/1ns
`default_nettype none
`include "twras_defs.vh"
// How it works
// RULE1 - slave only, never drives clock
// RULE2 - answers only fixed bus address 0x21
// RULE3 - start: data falls while clock high
// RULE4 - master sends address plus direction bit
// RULE5 - acknowledge own address, else stay silent
// RULE6 - release data after eight bits, ack ninth
// RULE7 - stop returns slave to idle standby
// RULE8 - write: two address bytes, data msb first
// RULE9 - read uses write address then restart
// RULE10 - ack and latch each register address byte
// RULE11 - read sends register as two bytes
// RULE12 - acked reads continue to next register
// RULE13 - address wraps from top to zero
// RULE14 - master ends read with stop
// RULE15 - writes advance address after each word
module twras_slave
(
   input  wire        sys_clk_i,
   input  wire        rstn_i,
   input  wire        scl_i,
   input  wire        sda_i,
   output reg         sda_o,
   output reg         sda_oe_o,
   output reg         wr_stb_o,
   output reg  [15:0] wr_addr_o,
   output reg  [15:0] wr_data_o,
   output reg         rd_stb_o,
   output reg  [15:0] rd_addr_o,
   input  wire [15:0] rd_data_i,
   output reg         busy_o
);
   localparam ST_IDLE  = 3'd0;
   localparam ST_DEVA  = 3'd1;
   localparam ST_ADRH  = 3'd2;
   localparam ST_ADRL  = 3'd3;
   localparam ST_WDAT  = 3'd4;
   localparam ST_RDAT  = 3'd5;

   wire scl;
   wire scl_rise;
   wire scl_fall;
   wire sda;
   wire sda_rise;
   wire sda_fall;

   reg  [2:0]  state;
   reg  [3:0]  bit_cnt;
   reg  [7:0]  shift;
   reg  [15:0] reg_addr;
   reg  [15:0] tx_word;
   reg         tx_low;
   reg         ack_phase;
   reg         wr_high;
   reg  [7:0]  wr_hi_byte;
   reg         ack_me;
   reg         rd_pending;

   twras_sync u_scl
   (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .async_i   (scl_i),
      .level_o   (scl),
      .rise_o    (scl_rise),
      .fall_o    (scl_fall)
   );

   twras_sync u_sda
   (
      .sys_clk_i (sys_clk_i),
      .rstn_i    (rstn_i),
      .async_i   (sda_i),
      .level_o   (sda),
      .rise_o    (sda_rise),
      .fall_o    (sda_fall)
   );

   wire start_det = scl & sda_fall; // see RULE3
   wire stop_det  = scl & sda_rise; // see RULE7
   wire [7:0] byte_in = {shift[6:0], sda};

   // see RULE13
   function [15:0] next_addr;
      input [15:0] a;
      begin
         next_addr = (a == `TWRAS_ADDR_TOP) ? `TWRAS_ADDR_RESET
                                            : a + 16'h0001;
      end
   endfunction

   // the slave drives data low for acks and high or low for read bits; clock is input only
   always @(posedge sys_clk_i) // see RULE1
   begin
      if (!rstn_i)
      begin
         state      <= ST_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         reg_addr   <= `TWRAS_ADDR_RESET;
         tx_word    <= 16'h0000;
         tx_low     <= 1'b0;
         ack_phase  <= 1'b0;
         wr_high    <= 1'b1;
         wr_hi_byte <= 8'h00;
         ack_me     <= 1'b0;
         rd_pending <= 1'b0;
         sda_o      <= 1'b0;
         sda_oe_o   <= 1'b0;
         wr_stb_o   <= 1'b0;
         wr_addr_o  <= 16'h0000;
         wr_data_o  <= 16'h0000;
         rd_stb_o   <= 1'b0;
         rd_addr_o  <= 16'h0000;
         busy_o     <= 1'b0;
      end
      else
      begin
         wr_stb_o <= 1'b0;
         rd_stb_o <= 1'b0;
         if (rd_pending)
         begin
            tx_word    <= rd_data_i; // see RULE11
            rd_pending <= 1'b0;
         end
         if (start_det)
         begin
            state     <= ST_DEVA;
            bit_cnt   <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe_o  <= 1'b0;
            busy_o    <= 1'b1;
         end
         else if (stop_det)
         begin
            state    <= ST_IDLE; // see RULE7
            sda_oe_o <= 1'b0;
            busy_o   <= 1'b0;
         end
         else if (state != ST_IDLE && scl_rise && !ack_phase)
         begin
            shift   <= byte_in;
            bit_cnt <= bit_cnt + 4'h1;
         end
         else if (state != ST_IDLE && scl_rise && ack_phase)
         begin
            // read: master nack ends output until the next start
            if (state == ST_RDAT && sda)
               state <= ST_IDLE;
         end
         else if (state != ST_IDLE && scl_fall)
         begin
            if (ack_phase)
            begin
               // ninth clock over: release or start next byte
               ack_phase <= 1'b0;
               bit_cnt   <= 4'h0;
               sda_oe_o  <= 1'b0;
               if (state == ST_RDAT)
               begin
                  sda_oe_o <= 1'b1;
                  sda_o    <= tx_low ? tx_word[7] : tx_word[15];
               end
            end
            else if (bit_cnt == `TWRAS_BITS_PER_BYTE)
            begin
               ack_phase <= 1'b1;
               sda_o     <= 1'b0;
               sda_oe_o  <= 1'b0;
               case (state)
                  ST_DEVA:
                  begin
                     // see RULE2 see RULE4 see RULE5
                     if (shift[7:1] == `TWRAS_DEV_ADDR)
                     begin
                        sda_oe_o <= 1'b1; // see RULE6
                        if (shift[`TWRAS_DIR_BIT])
                        begin
                           state     <= ST_RDAT; // see RULE9
                           rd_stb_o  <= 1'b1;
                           rd_addr_o <= reg_addr;
                           rd_pending <= 1'b1;
                           tx_low    <= 1'b0;
                        end
                        else
                           state <= ST_ADRH;
                     end
                     else
                        state <= ST_IDLE;
                  end
                  ST_ADRH:
                  begin
                     reg_addr[15:8] <= shift; // see RULE8 see RULE10
                     sda_oe_o       <= 1'b1;
                     state          <= ST_ADRL;
                  end
                  ST_ADRL:
                  begin
                     reg_addr[7:0] <= shift; // see RULE10
                     sda_oe_o      <= 1'b1;
                     wr_high       <= 1'b1;
                     state         <= ST_WDAT;
                  end
                  ST_WDAT:
                  begin
                     sda_oe_o <= 1'b1;
                     wr_high  <= ~wr_high;
                     if (wr_high)
                        wr_hi_byte <= shift; // see RULE8
                     else
                     begin
                        wr_stb_o  <= 1'b1;
                        wr_addr_o <= reg_addr;
                        wr_data_o <= {wr_hi_byte, shift};
                        reg_addr  <= next_addr(reg_addr); // see RULE15
                     end
                  end
                  ST_RDAT:
                  begin
                     // transmitter releases; master acks
                     if (tx_low)
                     begin
                        // see RULE12 see RULE13
                        reg_addr   <= next_addr(reg_addr);
                        rd_stb_o   <= 1'b1;
                        rd_addr_o  <= next_addr(reg_addr);
                        rd_pending <= 1'b1;
                     end
                     tx_low <= ~tx_low;
                  end
                  default:
                     state <= ST_IDLE;
               endcase
            end
            else if (state == ST_RDAT)
            begin
               sda_oe_o <= 1'b1;
               sda_o    <= tx_low ? tx_word[4'd7 - bit_cnt[2:0]]
                                  : tx_word[4'd15 - bit_cnt];
            end
         end
      end
   end
endmodule // twras_slave
`default_nettype wire

//--- sim/twras_properties.sv
`timescale 1ns/1ns
`default_nettype none
module twras_chk
(
   input wire logic        sys_clk_i,
   input wire logic        rstn_i,
   input wire logic        scl_i,
   input wire logic        sda_i,
   input wire logic        sda_oe_o,
   input wire logic        wr_stb_o,
   input wire logic [15:0] wr_addr_o,
   input wire logic        rd_stb_o,
   input wire logic        busy_o
);
   logic [15:0] lw;
   logic        hw;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);
   // remembers the last word address of the current transaction
   always @(posedge sys_clk_i)
   begin
      hw <= rstn_i && busy_o && (hw || wr_stb_o);
      lw <= wr_stb_o ? wr_addr_o : lw;
   end
   a_idle_no_drive: assert property (!busy_o |-> !sda_oe_o)
      else $error("drive when idle");
   a_start_busy: assert property ($fell(sda_i) && scl_i && $past(scl_i)
      |-> ##[1:6] busy_o) else $error("start missed");
   a_stop_idle: assert property ($rose(sda_i) && scl_i && $past(scl_i, 3)
      |-> ##[1:6] !busy_o) else $error("stop missed");
   a_wr_pulse: assert property (wr_stb_o |=> !wr_stb_o)
      else $error("write pulse");
   a_rd_pulse: assert property (rd_stb_o |=> !rd_stb_o)
      else $error("read pulse");
   a_wr_busy: assert property (wr_stb_o |-> busy_o)
      else $error("write outside");
   a_rd_busy: assert property (rd_stb_o |-> busy_o)
      else $error("read outside");
   a_wr_step: assert property (wr_stb_o && hw |-> wr_addr_o == lw + 16'h1)
      else $error("write step");
endmodule // twras_chk
bind twras_slave twras_chk chk_u (.sys_clk_i, .rstn_i, .scl_i, .sda_i,
   .sda_oe_o, .wr_stb_o, .wr_addr_o, .rd_stb_o, .busy_o);
`default_nettype wire

//--- sim/twras_master.sv
`timescale 1ns/1ns
`default_nettype none
module twras_master
(
   input  wire logic clk_i,
   input  wire logic sda_i,
   output var  logic scl_o = 1'b1,
   output var  logic sda_o = 1'b1
);
   task automatic q2();
      repeat (2) @(negedge clk_i);
   endtask
   // v=1 start, v=0 stop; data is set to v while the clock may be low, then moves to ~v while it is high
   task automatic cond(input logic v);
      q2();
      sda_o = v;
      q2();
      scl_o = 1'b1;
      q2();
      q2();
      sda_o = ~v;
      q2();
      scl_o = ~v;
   endtask
   task automatic bitx(input logic b, output logic r);
      q2();
      sda_o = b;
      q2();
      scl_o = 1'b1;
      repeat (3) @(negedge clk_i);
      r = sda_i;
      @(negedge clk_i);
      scl_o = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(a, k);
   endtask
endmodule // twras_master
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk(g, e)
module testbench;
   logic        sys_clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic [15:0] rd_data_i;
   logic [15:0] a;
   logic [15:0] wa [$];
   logic [15:0] wd [$];
   logic [7:0]  q;
   logic        ak;
   int          miscompares = 0;
   int          check_count = 0;
   int          seed = 32'h88fd;
   int          cyc = 0;
   wire         scl, sda_m, sda_s, sda_oe, wr_stb, rd_stb, busy;
   wire  [15:0] wr_addr, wr_data, rd_addr;
   wire         sda = (sda_oe ? sda_s : 1'b1) & sda_m;
   twras_slave dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_s), .sda_oe_o(sda_oe), .wr_stb_o(wr_stb),
      .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_stb_o(rd_stb),
      .rd_addr_o(rd_addr), .rd_data_i(rd_data_i), .busy_o(busy));
   twras_master m_u (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl),
      .sda_o(sda_m));
   function automatic logic [15:0] regv(input logic [15:0] x);
      return {x[7:0] ^ 8'h3c, x[15:8] ^ 8'ha5};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic tx(input logic [7:0] d, input logic e);
      m_u.xfer(d, 1'b1, q, ak);
      `CHK(ak, e);
   endtask
   task automatic hdr(input logic [15:0] x);
      m_u.cond(1'b1);
      tx(8'h42, 1'b0);
      tx(x[15:8], 1'b0);
      tx(x[7:0], 1'b0);
   endtask
   task automatic fin(input string s);
      repeat (8) @(negedge sys_clk_i);
      `CHK(busy, 1'b0);
      $display("%s test done", s);
   endtask
   task automatic wr(input logic [15:0] x, input int n);
      logic [15:0] d [8];
      hdr(x);
      for (int i = 0; i < n; i++)
      begin
         d[i] = $random(seed);
         tx(d[i][15:8], 1'b0);
         tx(d[i][7:0], 1'b0);
      end
      m_u.cond(1'b0);
      fin("write");
      `CHK(wa.size(), n);
      for (int i = 0; i < n && wa.size() > 0; i++)
      begin
         `CHK(wa.pop_front(), 16'(x + i));
         `CHK(wd.pop_front(), d[i]);
      end
   endtask
   task automatic rd(input logic [15:0] x, input int n);
      logic [7:0] hi;
      hdr(x);
      m_u.cond(1'b1);
      tx(8'h43, 1'b0);
      for (int i = 0; i < n; i++)
      begin
         m_u.xfer(8'hff, 1'b0, hi, ak);
         m_u.xfer(8'hff, i == n - 1, q, ak);
         `CHK({hi, q}, regv(16'(x + i)));
      end
      m_u.cond(1'b0);
      fin("read");
   endtask
   task automatic bad();
      logic [6:0] x;
      x = $random(seed);
      x = (x == 7'h21) ? 7'h20 : x;
      m_u.cond(1'b1);
      tx({x, 1'b0}, 1'b1);
      tx(8'h00, 1'b1);
      m_u.cond(1'b0);
      fin("address");
      `CHK(wa.size(), 0);
   endtask
   initial
      forever #5 sys_clk_i = ~sys_clk_i;
   always @(negedge sys_clk_i)
      rd_data_i <= regv(rd_addr);
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (wr_stb)
      begin
         wa.push_back(wr_addr);
         wd.push_back(wr_data);
      end
      if (cyc == 30000)
      begin
         miscompares++;
         complete_run();
      end
   end
   initial
   begin
      repeat (2) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      wr(16'hffff, 2);
      rd(16'hfffe, 3);
      bad();
      for (int i = 0; i < 4; i++)
      begin
         a = $random(seed);
         wr(a, 1 + i % 3);
         rd(a, 1 + i % 2);
      end
      complete_run();
   end
endmodule // testbench
`default_nettype wire
